// *** logic/drive_fault_supervisor.sv ***
/*
 Fault supervisor of a motor drive: thresholds, duration timers, fault
 actions and the running frequency after a tolerated fault, APB registers.
 Assumes measurements synchronous to clk; frequencies in 0.1 % of maximum.
*/
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ns
`include "drive_fault_supervisor_cfg.svh"
module drive_fault_supervisor #(
	parameter int TICK_CYCLES = `TICK_CYC
)(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        running,
	input  wire logic [9:0]  outCurrent,
	input  wire logic [10:0] actualSpeed,
	input  wire logic [10:0] setFreq,
	input  wire logic [10:0] upperFreq,
	input  wire logic [10:0] lowerFreq,
	input  wire logic [10:0] ratedFreq,
	input  wire logic [7:0]  motorTemp,
	input  wire logic        initialPositionFault,
	input  wire logic        loadLossFault,
	output logic      [10:0] freqCmd,
	output logic             coastStop,
	output logic             rampStop,
	output logic             overheatWarn,
	output logic             irq
);
	import drive_fault_pkg::*;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	logic [19:0] act4_r, act4_nxt;
	cont_sel_t   contSel_r, contSel_nxt;
	logic [9:0]  standby_r, standby_nxt;
	sensor_t     sensor_r, sensor_nxt;
	logic [7:0]  hotThr_r, hotThr_nxt, warnThr_r, warnThr_nxt;
	logic        offEn_r, offEn_nxt;
	logic [9:0]  offLvl_r, offLvl_nxt, offTime_r, offTime_nxt;
	logic [9:0]  ospMrg_r, ospMrg_nxt, ospTime_r, ospTime_nxt;
	logic [9:0]  devMrg_r, devMrg_nxt, devTime_r, devTime_nxt;
	logic [`ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt, stSet;
	logic [31:0] prdata_nxt;
	logic        wrEn, rdEn, hit;
	off_state_t  offState_r, offState_nxt;
	logic [4:0]  faultAct_r, faultAct_nxt;

	assign wrEn = psel && penable && pwrite;
	assign rdEn = psel && !penable;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;

	// Address decode and read data mux, read data captured in setup phase
	always_comb
	begin
		hit = 1'b1;
		prdata_nxt = prdata;
		case (paddr)
			`A_ACT4:     prdata_nxt = {12'h000, act4_r};
			`A_CONTSEL:  prdata_nxt = {29'h0, contSel_r};
			`A_STANDBY:  prdata_nxt = {22'h0, standby_r};
			`A_SENSOR:   prdata_nxt = {30'h0, sensor_r};
			`A_HOT_THR:  prdata_nxt = {24'h0, hotThr_r};
			`A_WARN_THR: prdata_nxt = {24'h0, warnThr_r};
			`A_OFF_EN:   prdata_nxt = {31'h0, offEn_r};
			`A_OFF_LVL:  prdata_nxt = {22'h0, offLvl_r};
			`A_OFF_TIME: prdata_nxt = {22'h0, offTime_r};
			`A_OSP_MRG:  prdata_nxt = {22'h0, ospMrg_r};
			`A_OSP_TIME: prdata_nxt = {22'h0, ospTime_r};
			`A_DEV_MRG:  prdata_nxt = {22'h0, devMrg_r};
			`A_DEV_TIME: prdata_nxt = {22'h0, devTime_r};
			`A_STATUS:   prdata_nxt = {25'h0, status_r};
			`A_MASK:     prdata_nxt = {25'h0, mask_r};
			`A_LIVE:     prdata_nxt = {15'h0000, freqCmd, offState_r, faultAct_r};
			default:     hit = 1'b0;
		endcase
		if (!rdEn)
			prdata_nxt = prdata;
		else if (!hit)
			prdata_nxt = 32'h0;
	end

	// Register writes; status bits set by events, cleared by writing one
	always_comb
	begin
		act4_nxt = act4_r;
		contSel_nxt = contSel_r;
		standby_nxt = standby_r;
		sensor_nxt = sensor_r;
		hotThr_nxt = hotThr_r;
		warnThr_nxt = warnThr_r;
		offEn_nxt = offEn_r;
		offLvl_nxt = offLvl_r;
		offTime_nxt = offTime_r;
		ospMrg_nxt = ospMrg_r;
		ospTime_nxt = ospTime_r;
		devMrg_nxt = devMrg_r;
		devTime_nxt = devTime_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		if (wrEn)
		begin
			case (paddr)
				`A_ACT4:     act4_nxt = pwdata[19:0];
				`A_CONTSEL:  contSel_nxt = cont_sel_t'(pwdata[2:0]);
				`A_STANDBY:  standby_nxt = pwdata[9:0];
				`A_SENSOR:   sensor_nxt = sensor_t'(pwdata[1:0]);
				`A_HOT_THR:  hotThr_nxt = pwdata[7:0];
				`A_WARN_THR: warnThr_nxt = pwdata[7:0];
				`A_OFF_EN:   offEn_nxt = pwdata[0];
				`A_OFF_LVL:  offLvl_nxt = pwdata[9:0];
				`A_OFF_TIME: offTime_nxt = pwdata[9:0];
				`A_OSP_MRG:  ospMrg_nxt = pwdata[9:0];
				`A_OSP_TIME: ospTime_nxt = pwdata[9:0];
				`A_DEV_MRG:  devMrg_nxt = pwdata[9:0];
				`A_DEV_TIME: devTime_nxt = pwdata[9:0];
				`A_STATUS:   status_nxt = status_r & ~pwdata[`ST_W-1:0];
				`A_MASK:     mask_nxt = pwdata[`ST_W-1:0];
				default:     ;
			endcase
		end
		status_nxt = status_nxt | stSet;
	end

	// Register bank
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prdata <= 32'h0;
			act4_r <= `R_ACT4;
			contSel_r <= CF_CURRENT;
			standby_r <= `R_STANDBY;
			sensor_r <= SNS_NONE;
			hotThr_r <= `R_HOT_THR;
			warnThr_r <= `R_WARN_THR;
			offEn_r <= 1'b0;
			offLvl_r <= `R_OFF_LVL;
			offTime_r <= `R_OFF_TIME;
			ospMrg_r <= `R_OSP_MRG;
			ospTime_r <= `R_OSP_TIME;
			devMrg_r <= `R_DEV_MRG;
			devTime_r <= `R_DEV_TIME;
			status_r <= '0;
			mask_r <= '0;
		end
		else
		begin
			prdata <= prdata_nxt;
			act4_r <= act4_nxt;
			contSel_r <= contSel_nxt;
			standby_r <= standby_nxt;
			sensor_r <= sensor_nxt;
			hotThr_r <= hotThr_nxt;
			warnThr_r <= warnThr_nxt;
			offEn_r <= offEn_nxt;
			offLvl_r <= offLvl_nxt;
			offTime_r <= offTime_nxt;
			ospMrg_r <= ospMrg_nxt;
			ospTime_r <= ospTime_nxt;
			devMrg_r <= devMrg_nxt;
			devTime_r <= devTime_nxt;
			status_r <= status_nxt;
			mask_r <= mask_nxt;
		end
	end

	assign irq = |(status_r & mask_r);

	// ------------------------------------------------------------
	// Comparators and duration timers
	// ------------------------------------------------------------
	logic [31:0] tick_r, tick_nxt;
	logic        tick;
	logic [10:0] tmr_r [3], tmr_nxt [3];
	logic [2:0]  cond, expired;
	logic [9:0]  lim [3];
	logic [10:0] devAbs;
	logic        hotCond, warnCond;

	assign tick = (tick_r == 32'(TICK_CYCLES - 1));
	assign devAbs = (actualSpeed >= setFreq) ? actualSpeed - setFreq : setFreq - actualSpeed;
	assign lim[0] = offTime_r;
	assign lim[1] = ospTime_r;
	assign lim[2] = devTime_r;
	assign hotCond = (sensor_r != SNS_NONE) && (motorTemp > hotThr_r);
	assign warnCond = (sensor_r != SNS_NONE) && (motorTemp > warnThr_r);

	// Conditions and timers counting 0.1 s ticks, saturating past the limit
	always_comb
	begin
		tick_nxt = tick ? 32'h0 : tick_r + 32'h1;
		cond[0] = offEn_r && running && offState_r == OFF_IDLE
			&& outCurrent < offLvl_r;
		cond[1] = (ospTime_r != 10'h0)
			&& {1'b0, actualSpeed} > `FULL_SCALE + {2'b00, ospMrg_r};
		cond[2] = (devTime_r != 10'h0) && devAbs > {1'b0, devMrg_r};
		for (int i = 0; i < 3; i++)
		begin
			if (!cond[i])
				tmr_nxt[i] = 11'h0;
			else if (tick && tmr_r[i] <= {1'b0, lim[i]})
				tmr_nxt[i] = tmr_r[i] + 11'h1;
			else
				tmr_nxt[i] = tmr_r[i];
			expired[i] = cond[i] && tmr_r[i] > {1'b0, lim[i]};
		end
	end

	// Tick prescaler and timer registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			tick_r <= 32'h0;
			for (int i = 0; i < 3; i++)
				tmr_r[i] <= 11'h0;
		end
		else
		begin
			tick_r <= tick_nxt;
			for (int i = 0; i < 3; i++)
				tmr_r[i] <= tmr_nxt[i];
		end
	end

	// ------------------------------------------------------------
	// Fault latches, actions and frequency command
	// ------------------------------------------------------------
	logic [4:0]  detect;
	logic [3:0]  isCoast, isRamp, isRun;
	logic        tolerating, warn_r, warn_nxt;
	logic [10:0] freq_nxt, offFreq;
	logic [21:0] offProd;

	assign detect = {hotCond, loadLossFault, initialPositionFault, expired[1], expired[2]};
	assign offProd = {11'h0, ratedFreq} * `OFF_NUM / `OFF_DEN;
	assign offFreq = offProd[10:0];

	// Decode the four low action digits of the selector; the top digit is unused
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			isRamp[i] = act4_r[4*i +: 4] == 4'h1;
			isRun[i] = act4_r[4*i +: 4] == 4'h2;
			isCoast[i] = !isRamp[i] && !isRun[i];
		end
	end

	assign coastStop = |(faultAct_r[3:0] & isCoast) || faultAct_r[4];
	assign rampStop = !coastStop && |(faultAct_r[3:0] & isRamp);
	assign tolerating = running && !coastStop && !rampStop
		&& |(faultAct_r[3:0] & isRun);

	// Faults latch until the drive stops; off-load state; frequency choice
	always_comb
	begin
		faultAct_nxt = running ? (faultAct_r | detect) : detect;
		warn_nxt = warnCond;
		offState_nxt = offState_r;
		case (offState_r)
			OFF_IDLE:
				if (expired[0])
					offState_nxt = OFF_ACTIVE;
			OFF_ACTIVE:
				if (!offEn_r || !running || outCurrent >= offLvl_r)
					offState_nxt = OFF_IDLE;
			default: offState_nxt = OFF_IDLE;
		endcase
		freq_nxt = setFreq;
		if (tolerating)
		begin
			case (contSel_r)
				CF_CURRENT: freq_nxt = freqCmd;
				CF_SET:     freq_nxt = setFreq;
				CF_UPPER:   freq_nxt = upperFreq;
				CF_LOWER:   freq_nxt = lowerFreq;
				CF_STANDBY: freq_nxt = {1'b0, standby_r};
				default:    freq_nxt = freqCmd;
			endcase
		end
		else if (offState_r == OFF_ACTIVE)
			freq_nxt = offFreq;
		stSet = {offState_nxt == OFF_ACTIVE && offState_r == OFF_IDLE,
			warn_nxt && !warn_r, detect & ~faultAct_r};
	end

	// Fault, warning, off-load and frequency registers
	always_ff @(posedge clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			faultAct_r <= 5'h00;
			warn_r <= 1'b0;
			offState_r <= OFF_IDLE;
			freqCmd <= 11'h000;
		end
		else
		begin
			faultAct_r <= faultAct_nxt;
			warn_r <= warn_nxt;
			offState_r <= offState_nxt;
			freqCmd <= freq_nxt;
		end
	end

	assign overheatWarn = warn_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_hot;
		@(posedge clk) disable iff (!reset_n) hotCond |=> coastStop;
	endproperty
	a_hot: assert property (p_hot) else $error("overheat not coasting");

	property p_warn;
		@(posedge clk) disable iff (!reset_n) warnCond |=> overheatWarn;
	endproperty
	a_warn: assert property (p_warn) else $error("warning missing");

	property p_ospOff;
		@(posedge clk) disable iff (!reset_n)
		(ospTime_r == 10'h0 && !faultAct_r[1]) |=> !faultAct_r[1];
	endproperty
	a_ospOff: assert property (p_ospOff) else $error("overspeed while off");

	property p_devOff;
		@(posedge clk) disable iff (!reset_n)
		(devTime_r == 10'h0 && !faultAct_r[0]) |=> !faultAct_r[0];
	endproperty
	a_devOff: assert property (p_devOff) else $error("deviation while off");

	property p_restart;
		@(posedge clk) disable iff (!reset_n) !cond[2] |=> tmr_r[2] == 11'h0;
	endproperty
	a_restart: assert property (p_restart) else $error("timer not restarted");

	property p_ospRaise;
		@(posedge clk) disable iff (!reset_n)
		running && cond[1] && tmr_r[1] > {1'b0, ospTime_r} |=> faultAct_r[1];
	endproperty
	a_ospRaise: assert property (p_ospRaise) else $error("overspeed missed");

	property p_contSet;
		@(posedge clk) disable iff (!reset_n)
		tolerating && contSel_r == CF_SET |=> freqCmd == $past(setFreq);
	endproperty
	a_contSet: assert property (p_contSet) else $error("wrong continue freq");

	property p_offFreq;
		@(posedge clk) disable iff (!reset_n)
		offState_r == OFF_ACTIVE && !tolerating |=> freqCmd == $past(offFreq);
	endproperty
	a_offFreq: assert property (p_offFreq) else $error("off-load freq wrong");

	property p_recover;
		@(posedge clk) disable iff (!reset_n)
		offState_r == OFF_ACTIVE && outCurrent >= offLvl_r |=> offState_r == OFF_IDLE;
	endproperty
	a_recover: assert property (p_recover) else $error("no recovery");

	property p_offDis;
		@(posedge clk) disable iff (!reset_n) !offEn_r |=> offState_r == OFF_IDLE;
	endproperty
	a_offDis: assert property (p_offDis) else $error("off-load while off");

	c_tol: cover property (@(posedge clk) disable iff (!reset_n) tolerating);
	c_off: cover property (@(posedge clk) disable iff (!reset_n) offState_r == OFF_ACTIVE);
	c_ramp: cover property (@(posedge clk) disable iff (!reset_n) rampStop);
endmodule

// *** logic/drive_fault_supervisor_cfg.svh ***
/*
 Constants of the drive fault supervisor: offsets, reset values, timing.
 Assumes a 50 MHz system clock and an APB master with 32-bit data.
*/
`ifndef DRIVE_FAULT_SUPERVISOR_CFG_SVH
`define DRIVE_FAULT_SUPERVISOR_CFG_SVH

// Register byte offsets
`define A_ACT4      8'h00
`define A_CONTSEL   8'h04
`define A_STANDBY   8'h08
`define A_SENSOR    8'h0C
`define A_HOT_THR   8'h10
`define A_WARN_THR  8'h14
`define A_OFF_EN    8'h18
`define A_OFF_LVL   8'h1C
`define A_OFF_TIME  8'h20
`define A_OSP_MRG   8'h24
`define A_OSP_TIME  8'h28
`define A_DEV_MRG   8'h2C
`define A_DEV_TIME  8'h30
`define A_STATUS    8'h34
`define A_MASK      8'h38
`define A_LIVE      8'h3C

// Reset values (times in 0.1 s, levels in 0.1 %)
`define R_ACT4      20'h00000
`define R_STANDBY   10'h3E8
`define R_HOT_THR   8'h6E
`define R_WARN_THR  8'h5A
`define R_OFF_LVL   10'h064
`define R_OFF_TIME  10'h00A
`define R_OSP_MRG   10'h0C8
`define R_OSP_TIME  10'h00A
`define R_DEV_MRG   10'h0C8
`define R_DEV_TIME  10'h032

// Full scale of maximum frequency, and 7 % of rated as a ratio
`define FULL_SCALE  12'h3E8
`define OFF_NUM     22'h000007
`define OFF_DEN     22'h000064

// Status bit positions
`define S_DEV   0
`define S_OSP   1
`define S_POS   2
`define S_LOAD  3
`define S_HOT   4
`define S_WARN  5
`define S_OFF   6
`define ST_W    7

// Supervision time unit in ns and clock period in ns
`define TIME_UNIT_NS 100000000
`define CLK_NS       20
`define TICK_CYC     (`TIME_UNIT_NS / `CLK_NS)

`endif

// *** logic/drive_fault_pkg.sv ***
/*
 Types of the drive fault supervisor.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package drive_fault_pkg;
	typedef enum logic [1:0] {ACT_COAST = 2'b00, ACT_RAMP = 2'b01, ACT_RUN = 2'b10} action_t;
	typedef enum logic [2:0] {
		CF_CURRENT = 3'b000,
		CF_SET     = 3'b001,
		CF_UPPER   = 3'b010,
		CF_LOWER   = 3'b011,
		CF_STANDBY = 3'b100
	} cont_sel_t;
	typedef enum logic [1:0] {SNS_NONE = 2'b00, SNS_PT100 = 2'b01, SNS_PT1000 = 2'b10} sensor_t;
	typedef enum logic {OFF_IDLE = 1'b0, OFF_ACTIVE = 1'b1} off_state_t;
endpackage

// *** bench/motor_model.sv ***
/*
 Motor model at the far side of the supervisor: speed tracks the
 frequency command plus an offset, current and temperature come from the bench.
 Assumes the supervisor's 0.1 % of maximum frequency units.
*/
`timescale 1ns/1ns
module motor_model (
	input  wire logic        [10:0] freqCmd,
	input  wire logic               coastStop,
	input  wire logic signed [11:0] speedOffset,
	input  wire logic        [9:0]  loadLevel,
	input  wire logic        [7:0]  tempNow,
	output logic             [10:0] actualSpeed,
	output logic             [9:0]  outCurrent,
	output logic             [7:0]  motorTemp
);
	// A coasting rotor is taken as stopped at once, with no current drawn
	always_comb
	begin
		actualSpeed = coastStop ? 11'h000 : 11'(12'(freqCmd) + speedOffset);
		outCurrent  = coastStop ? 10'h000 : loadLevel;
		motorTemp   = tempNow;
	end
endmodule

// *** bench/drive_fault_supervisor_tb_top.sv ***
/*
 Self-checking bench of the drive fault supervisor with a motor model.
 Assumes the register map and reset values of the supervisor's header.
*/
`timescale 1ns/1ns
`include "drive_fault_supervisor_cfg.svh"
module drive_fault_supervisor_tb_top;
	localparam int TK = 10;
	logic              clk = 1'b0;
	logic              resetN = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic        [7:0] paddr = 8'h00;
	logic       [31:0] pwdata = 32'h0;
	logic       [31:0] prdata;
	logic              pready, pslverr, coastStop, rampStop, overheatWarn, irq;
	logic              running = 1'b0;
	logic              posFlt = 1'b0;
	logic              llFlt = 1'b0;
	logic       [10:0] setFreq = 11'h258;
	logic       [10:0] upperFreq = 11'h384;
	logic       [10:0] lowerFreq = 11'h064;
	logic       [10:0] ratedFreq = 11'h3E8;
	logic       [10:0] freqCmd, actualSpeed, sf;
	logic        [9:0] outCurrent;
	logic        [9:0] loadLevel = 10'h0C8;
	logic        [7:0] motorTemp;
	logic        [7:0] tempNow = 8'h19;
	logic signed [11:0] speedOffset = 12'sh000;
	logic       [32:0] expQ [$];
	logic       [31:0] seed = 32'h58;
	logic       [31:0] rstv [0:14] = '{32'(`R_ACT4), 32'h0, 32'(`R_STANDBY), 32'h0,
		32'(`R_HOT_THR), 32'(`R_WARN_THR), 32'h0, 32'(`R_OFF_LVL), 32'(`R_OFF_TIME),
		32'(`R_OSP_MRG), 32'(`R_OSP_TIME), 32'(`R_DEV_MRG), 32'(`R_DEV_TIME), 32'h0, 32'h0};
	int                errTotal = 0;
	int                checkCount = 0;
	int                cycles = 0;

	// Clock of 20 ns period
	initial
	begin
		forever #10 clk = ~clk;
	end

	drive_fault_supervisor #(.TICK_CYCLES(TK)) dut (
		.clk(clk), .reset_n(resetN), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .running(running), .outCurrent(outCurrent),
		.actualSpeed(actualSpeed), .setFreq(setFreq), .upperFreq(upperFreq),
		.lowerFreq(lowerFreq), .ratedFreq(ratedFreq), .motorTemp(motorTemp),
		.initialPositionFault(posFlt), .loadLossFault(llFlt), .freqCmd(freqCmd),
		.coastStop(coastStop), .rampStop(rampStop), .overheatWarn(overheatWarn), .irq(irq));

	motor_model plant (
		.freqCmd(freqCmd), .coastStop(coastStop), .speedOffset(speedOffset),
		.loadLevel(loadLevel), .tempNow(tempNow), .actualSpeed(actualSpeed),
		.outCurrent(outCurrent), .motorTemp(motorTemp));

	// ----------------------------------------
	// Checking and reporting
	// ----------------------------------------
	function automatic logic [31:0] xrnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic tally(input logic [32:0] got, input logic [32:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			errTotal++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkRd(input logic [32:0] got, input logic [32:0] exp);
		tally(got, exp);
	endtask

	task automatic chkPin(input logic [10:0] got, input logic [10:0] exp);
		tally({22'h0, got}, {22'h0, exp});
	endtask

	task automatic results();
		$display("Checks %0d, mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Takes the oldest noted read result when a read completes
	always @(posedge clk)
	begin
		if (psel && penable && pready === 1'b1 && !pwrite && expQ.size() > 0)
			chkRd({pslverr, prdata}, expQ.pop_front());
	end

	// Cuts a hang short
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errTotal++;
			results();
		end
	end

	// ----------------------------------------
	// Bus and stimulus tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		if (!wr) expQ.push_back(e);
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, {1'b0, e});
	endtask

	task automatic ticks(input int n);
		repeat (n * TK) @(posedge clk);
	endtask

	// Stop, let latches follow the quiet inputs, clear status, run again
	task automatic clrFault();
		running <= 1'b0;
		speedOffset <= 12'sh000;
		repeat (3) @(posedge clk);
		wr(`A_STATUS, 32'h7F);
		running <= 1'b1;
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (10) @(posedge clk);
		resetN <= 1'b1;
		for (int i = 0; i < 15; i++) rd(8'(i * 4), rstv[i]);
		apb(1'b0, 8'h40, 32'h0, {1'b1, 32'h0});
		// Temperature without sensor, then warning and fault levels
		tempNow <= 8'h64;
		repeat (3) @(posedge clk);
		chkPin(11'(overheatWarn), 11'h0);
		wr(`A_SENSOR, 32'h1);
		repeat (3) @(posedge clk);
		chkPin(11'({coastStop, overheatWarn}), 11'h1);
		wr(`A_SENSOR, 32'h2);
		tempNow <= 8'h6F;
		repeat (3) @(posedge clk);
		chkPin(11'(coastStop), 11'h1);
		tempNow <= 8'h6E;
		repeat (3) @(posedge clk);
		chkPin(11'(coastStop), 11'h0);
		tempNow <= 8'h19;
		// Position and load loss faults each read their own digit
		wr(`A_ACT4, 32'h00100);
		posFlt <= 1'b1;
		repeat (3) @(posedge clk);
		chkPin(11'({coastStop, rampStop}), 11'h1);
		posFlt <= 1'b0;
		llFlt <= 1'b1;
		repeat (3) @(posedge clk);
		chkPin(11'({coastStop, rampStop}), 11'h2);
		llFlt <= 1'b0;
		clrFault();
		// Overspeed under coast, ramp and run in its own digit, and every continue code
		wr(`A_DEV_TIME, 32'h0);
		wr(`A_OSP_TIME, 32'h2);
		wr(`A_STANDBY, 32'h1F4);
		for (int i = 0; i < 7; i++)
		begin
			sf = 11'h12C + 11'(xrnd() % 400);
			setFreq <= sf;
			speedOffset <= 12'(12'h4B1 - {1'b0, sf});
			wr(`A_ACT4, 32'((i < 2 ? i : 2) << 4));
			wr(`A_CONTSEL, 32'(i < 2 ? 4 : i - 2));
			rd(`A_STATUS, 32'h0);
			ticks(5);
			rd(`A_STATUS, 32'h2);
			chkPin(11'({coastStop, rampStop}), i == 0 ? 11'h2 : i == 1 ? 11'h1 : 11'h0);
			if (i >= 2) chkPin(freqCmd, i < 4 ? sf : i == 4 ? 11'h384 : i == 5 ? 11'h064 : 11'h1F4);
			clrFault();
		end
		// Zero detection time turns overspeed off
		setFreq <= 11'h258;
		wr(`A_OSP_TIME, 32'h0);
		speedOffset <= 12'sh2BC;
		ticks(6);
		rd(`A_STATUS, 32'h0);
		clrFault();
		// Deviation timer restarts each time the error drops, then trips
		wr(`A_DEV_TIME, 32'h3);
		wr(`A_ACT4, 32'h2);
		wr(`A_MASK, 32'h1);
		repeat (3)
		begin
			speedOffset <= 12'sh0FA;
			ticks(2);
			speedOffset <= 12'sh000;
			ticks(1);
		end
		rd(`A_STATUS, 32'h0);
		speedOffset <= 12'sh0FA;
		ticks(7);
		rd(`A_STATUS, 32'h1);
		chkPin(11'({coastStop, rampStop, irq}), 11'h1);
		wr(`A_MASK, 32'h0);
		repeat (2) @(posedge clk);
		chkPin(11'(irq), 11'h0);
		clrFault();
		wr(`A_MASK, 32'h1);
		repeat (2) @(posedge clk);
		chkPin(11'(irq), 11'h0);
		// Off-load: disabled, entered, left on recovery
		wr(`A_DEV_TIME, 32'h0);
		wr(`A_OFF_TIME, 32'h2);
		loadLevel <= 10'h032;
		ticks(6);
		chkPin(freqCmd, 11'h258);
		wr(`A_OFF_EN, 32'h1);
		ticks(6);
		chkPin(freqCmd, 11'h046);
		// Off-load frequency scales with the rated frequency
		ratedFreq <= 11'h1F4;
		repeat (3) @(posedge clk);
		chkPin(freqCmd, 11'h023);
		loadLevel <= 10'h0C8;
		repeat (4) @(posedge clk);
		chkPin(freqCmd, 11'h258);
		results();
	end
endmodule
